// file: adc_serial_port.sv
/*
  serial output and control side of a 16-bit sigma-delta converter.
  assumes conv_clk and all host pins are asynchronous to ref_clk, which
  runs several times faster; sample words come from the on-chip filter
  on ref_clk with a valid/ready handshake.
*/
// What this block does
// - serial mode two clock cycles later
// - new-word flag rises when word ready
// - flag held low during sync or calibration
// - sixteen bit words, most significant first
// - data changes on shift clock rising edge
// - drive data only after frame goes low
// - data line high impedance while frame high
// - shift clock comes from converter clock
// - realign rising edge starts synchronisation
// - range low unipolar, high bipolar
// - trim request rising edge starts calibration
// - sleep select high enters standby
// - word-valid pin is data-valid output only
module adc_serial_port #(
  parameter int WORD_W = adc_serial_pkg::WORD_BITS,
  parameter int SETTLE = adc_serial_pkg::SETTLE_EDGES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic conv_clk,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic store_n,
  input wire logic frame_enable_n,
  input wire logic realign_in,
  input wire logic range_polarity_select,
  input wire logic trim_request,
  input wire logic sleep_select,
  input wire logic [WORD_W-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic new_word_flag,
  output logic shift_clock_out,
  output logic serial_out_line,
  output logic serial_out_oe_n,
  output logic word_valid_out,
  output logic serial_mode,
  output logic standby_out,
  output logic busy_out
);

  localparam int SW = $clog2(SETTLE + 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE - 1);

  logic [adc_serial_pkg::PIN_COUNT-1:0] pins_raw, pins_s;
  logic clk_s, clk_d_r, clk_rise;
  logic sel_s, rd_s, st_s, frame_s, realign_s, realign_d_r;
  logic range_s, trim_s, trim_d_r, sleep_s;
  logic realign_rise, trim_rise, strobes_low;

  adc_serial_pkg::port_state_t state_r, state_nxt;
  logic [adc_serial_pkg::CNT_BITS-1:0] mode_cnt_r, mode_cnt_nxt;
  logic [adc_serial_pkg::CNT_BITS-1:0] bit_cnt_r, bit_cnt_nxt;
  logic [SW-1:0] settle_cnt_r, settle_cnt_nxt;
  logic [WORD_W-1:0] shift_r, shift_nxt;
  logic flag_r, flag_nxt, sclk_r, sclk_nxt;
  logic sdo_r, sdo_nxt, oe_n_r, oe_n_nxt, dval_r, dval_nxt;

  logic buf_flush, buf_in_valid, buf_in_ready;
  logic buf_out_valid, buf_out_ready;
  logic [WORD_W-1:0] buf_out_data;

  assign pins_raw = {sleep_select, trim_request, range_polarity_select,
                     realign_in, frame_enable_n, store_n, read_n,
                     select_n, conv_clk};

  pin_sync #(
    .WIDTH(adc_serial_pkg::PIN_COUNT),
    .INIT(adc_serial_pkg::PIN_RESET)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign clk_s = pins_s[adc_serial_pkg::PIN_CLK];
  assign sel_s = pins_s[adc_serial_pkg::PIN_SEL];
  assign rd_s = pins_s[adc_serial_pkg::PIN_RD];
  assign st_s = pins_s[adc_serial_pkg::PIN_ST];
  assign frame_s = pins_s[adc_serial_pkg::PIN_FRAME];
  assign realign_s = pins_s[adc_serial_pkg::PIN_REALIGN];
  assign range_s = pins_s[adc_serial_pkg::PIN_RANGE];
  assign trim_s = pins_s[adc_serial_pkg::PIN_TRIM];
  assign sleep_s = pins_s[adc_serial_pkg::PIN_SLEEP];

  // edge finders on synchronised levels only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_d_r <= 1'b0;
      realign_d_r <= 1'b0;
      trim_d_r <= 1'b0;
    end else begin
      clk_d_r <= clk_s;
      realign_d_r <= realign_s;
      trim_d_r <= trim_s;
    end
  end

  assign clk_rise = clk_s && !clk_d_r;
  assign realign_rise = realign_s && !realign_d_r;
  // a held trim level would restart calibration forever, so use its edge
  assign trim_rise = trim_s && !trim_d_r;
  assign strobes_low = !sel_s && !rd_s && !st_s;

  // filter words only enter while conversions run
  assign buf_in_valid = sample_valid &&
                        (state_r != adc_serial_pkg::ST_WAIT_MODE) &&
                        (state_r != adc_serial_pkg::ST_SETTLE) &&
                        (state_r != adc_serial_pkg::ST_SLEEP);
  assign sample_ready = buf_in_ready && buf_in_valid;

  word_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(2)
  ) u_word_buffer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .flush(buf_flush),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(sample_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // bipolar output is two's complement: flip the offset-binary sign bit
  function automatic logic [WORD_W-1:0] range_code(
    input logic [WORD_W-1:0] raw,
    input logic bipolar
  );
    logic [WORD_W-1:0] res;
    res = raw;
    if (bipolar) res[WORD_W-1] = ~raw[WORD_W-1];
    return res;
  endfunction : range_code

  always_comb begin
    state_nxt = state_r;
    mode_cnt_nxt = mode_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    settle_cnt_nxt = settle_cnt_r;
    shift_nxt = shift_r;
    flag_nxt = flag_r;
    sdo_nxt = sdo_r;
    oe_n_nxt = 1'b1;
    dval_nxt = dval_r;
    buf_flush = 1'b0;
    buf_out_ready = 1'b0;
    // shift clock mirrors the converter clock once serial mode runs
    sclk_nxt = (state_r == adc_serial_pkg::ST_WAIT_MODE) ? 1'b0 : clk_s;
    case (state_r)
      adc_serial_pkg::ST_WAIT_MODE: begin
        flag_nxt = 1'b0;
        if (!strobes_low) begin
          mode_cnt_nxt = '0;
        end else if (clk_rise) begin
          mode_cnt_nxt = mode_cnt_r + 1'b1;
          if (mode_cnt_r + 1'b1 == adc_serial_pkg::MODE_EDGES) begin
            state_nxt = adc_serial_pkg::ST_IDLE;
          end
        end
      end
      adc_serial_pkg::ST_IDLE: begin
        flag_nxt = 1'b0;
        dval_nxt = 1'b0;
        if (clk_rise && buf_out_valid) begin
          flag_nxt = 1'b1;
          state_nxt = adc_serial_pkg::ST_FLAG;
        end
      end
      adc_serial_pkg::ST_FLAG: begin
        // one converter clock high, then falling flag frames the word
        if (clk_rise) begin
          flag_nxt = 1'b0;
          state_nxt = adc_serial_pkg::ST_FRAME;
        end
      end
      adc_serial_pkg::ST_FRAME: begin
        if (clk_rise && !frame_s) begin
          buf_out_ready = 1'b1;
          shift_nxt = range_code(buf_out_data, range_s);
          sdo_nxt = shift_nxt[WORD_W-1];
          bit_cnt_nxt = adc_serial_pkg::BIT_LAST;
          dval_nxt = 1'b1;
          oe_n_nxt = 1'b0;
          state_nxt = adc_serial_pkg::ST_SHIFT;
        end
      end
      adc_serial_pkg::ST_SHIFT: begin
        oe_n_nxt = frame_s;
        if (clk_rise) begin
          if (bit_cnt_r == '0) begin
            oe_n_nxt = 1'b1;
            dval_nxt = 1'b0;
            state_nxt = adc_serial_pkg::ST_IDLE;
          end else begin
            shift_nxt = {shift_r[WORD_W-2:0], 1'b0};
            sdo_nxt = shift_r[WORD_W-2];
            bit_cnt_nxt = bit_cnt_r - 1'b1;
          end
        end
      end
      adc_serial_pkg::ST_SETTLE: begin
        flag_nxt = 1'b0;
        dval_nxt = 1'b0;
        buf_flush = 1'b1;
        if (clk_rise) begin
          settle_cnt_nxt = settle_cnt_r + 1'b1;
          if (settle_cnt_r == SETTLE_LAST) begin
            state_nxt = adc_serial_pkg::ST_IDLE;
          end
        end
      end
      adc_serial_pkg::ST_SLEEP: begin
        flag_nxt = 1'b0;
        dval_nxt = 1'b0;
        buf_flush = 1'b1;
        // stale words are dropped; fresh ones follow after wake-up
        if (!sleep_s) state_nxt = adc_serial_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = adc_serial_pkg::ST_WAIT_MODE;
      end
    endcase
    // sleep outranks sync and calibration; both abort a word in flight
    if (state_r != adc_serial_pkg::ST_WAIT_MODE) begin
      if (sleep_s) begin
        state_nxt = adc_serial_pkg::ST_SLEEP;
        buf_flush = 1'b1;
        flag_nxt = 1'b0;
        dval_nxt = 1'b0;
        oe_n_nxt = 1'b1;
      end else if (realign_rise || trim_rise) begin
        state_nxt = adc_serial_pkg::ST_SETTLE;
        settle_cnt_nxt = '0;
        buf_flush = 1'b1;
        flag_nxt = 1'b0;
        dval_nxt = 1'b0;
        oe_n_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= adc_serial_pkg::ST_WAIT_MODE;
      mode_cnt_r <= '0;
      bit_cnt_r <= '0;
      settle_cnt_r <= '0;
      shift_r <= adc_serial_pkg::WORD_RESET;
      flag_r <= 1'b0;
      sclk_r <= 1'b0;
      sdo_r <= 1'b0;
      oe_n_r <= 1'b1;
      dval_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_cnt_r <= mode_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      shift_r <= shift_nxt;
      flag_r <= flag_nxt;
      sclk_r <= sclk_nxt;
      sdo_r <= sdo_nxt;
      oe_n_r <= oe_n_nxt;
      dval_r <= dval_nxt;
    end
  end

  assign new_word_flag = flag_r;
  assign shift_clock_out = sclk_r;
  assign serial_out_line = sdo_r;
  assign serial_out_oe_n = oe_n_r;
  assign word_valid_out = dval_r;
  assign serial_mode = (state_r != adc_serial_pkg::ST_WAIT_MODE);
  assign standby_out = (state_r == adc_serial_pkg::ST_SLEEP);
  assign busy_out = (state_r == adc_serial_pkg::ST_SETTLE);

endmodule : adc_serial_port

// file: adc_serial_pkg.sv
/*
  shared constants for the serial side of the 16-bit sigma-delta converter.
  assumes a 200 MHz ref_clk and a slower converter clock sampled on it.
*/
package adc_serial_pkg;

  localparam int WORD_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam int SYNC_STAGES = 2;

  // converter clock edges with the strobes low before serial mode starts
  localparam logic [CNT_BITS-1:0] MODE_EDGES = 5'h02;
  // converter clock edges a sync or calibration cycle occupies
  localparam int SETTLE_EDGES = 32;

  // bit positions inside the synchronised pin vector
  localparam int PIN_CLK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_RD = 2;
  localparam int PIN_ST = 3;
  localparam int PIN_FRAME = 4;
  localparam int PIN_REALIGN = 5;
  localparam int PIN_RANGE = 6;
  localparam int PIN_TRIM = 7;
  localparam int PIN_SLEEP = 8;
  localparam int PIN_COUNT = 9;
  // reset image of the pin vector: frame input idles high
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 9'h010;

  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic [CNT_BITS-1:0] BIT_LAST = 5'h0F;

  typedef enum logic [6:0] {
    ST_WAIT_MODE = 7'b0000001,
    ST_IDLE = 7'b0000010,
    ST_FLAG = 7'b0000100,
    ST_FRAME = 7'b0001000,
    ST_SHIFT = 7'b0010000,
    ST_SETTLE = 7'b0100000,
    ST_SLEEP = 7'b1000000
  } port_state_t;

endpackage : adc_serial_pkg

// file: pin_sync.sv
/*
  two-flop synchroniser for a vector of independent level inputs.
  assumes each bit is a slow level; no bus coherence across bits.
*/
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : pin_sync

// file: word_buffer.sv
/*
  two-entry word buffer with valid/ready on both sides and a flush.
  assumes both sides run on ref_clk.
*/
module word_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      wr_nxt = '0;
      rd_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) wr_nxt = PW'((wr_r + 1'b1) % DEPTH);
      if (pop) rd_nxt = PW'((rd_r + 1'b1) % DEPTH);
      if (push && !pop) cnt_nxt = cnt_r + 1'b1;
      else if (pop && !push) cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage carries no reset; out_valid guards it
  always_ff @(posedge ref_clk) begin
    if (push && !flush) mem_r[wr_r] <= in_data;
  end

endmodule : word_buffer

// file: host_rx_model.sv
/*
  host serial receive port: gathers words shifted out by the converter.
  assumes the converter's serial pins are wired straight to it.
*/
module host_rx_model (
  input wire logic shift_clock_out,
  input wire logic serial_out_line,
  input wire logic serial_out_oe_n,
  input wire logic new_word_flag,
  output logic frame_enable_n,
  output logic select_n,
  output logic read_n,
  output logic store_n,
  output logic [15:0] rx_word,
  output int rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] shift_r = 16'h0000;
  int bits = 0;
  // strobes low from power-up on; test pins have no ports to ground
  assign select_n = 1'b0;
  assign read_n = 1'b0;
  assign store_n = 1'b0;
  assign frame_enable_n = new_word_flag;
  initial begin
    rx_word = 16'h0000;
    rx_count = 0;
  end
  // released line is ignored; an aborted word restarts the count
  always @(negedge shift_clock_out) begin
    if (serial_out_oe_n) begin
      bits = 0;
    end else begin
      shift_r = {shift_r[14:0], serial_out_line};
      bits = bits + 1;
      if (bits == 16) begin
        bits = 0;
        rx_word = shift_r;
        rx_count = rx_count + 1;
      end
    end
  end
endmodule : host_rx_model

// file: adc_serial_port_assertions.sv
/*
  concurrent checks on the converter serial port.
  assumes conv_clk near 48 ns against a 5 ns ref_clk.
*/
module adc_serial_checker #(
  parameter int WORD_W = 16,
  parameter int SETTLE = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic conv_clk,
  input wire logic frame_enable_n,
  input wire logic realign_in,
  input wire logic trim_request,
  input wire logic sleep_select,
  input wire logic new_word_flag,
  input wire logic shift_clock_out,
  input wire logic serial_out_line,
  input wire logic serial_out_oe_n,
  input wire logic word_valid_out,
  input wire logic serial_mode,
  input wire logic standby_out,
  input wire logic busy_out
);
  // 9.6 ref_clk per bit; sync jitter widens the window
  localparam int LEN_MIN = WORD_W * 9;
  localparam int LEN_MAX = WORD_W * 10;
  logic [9:0] len_r;
  logic [9:0] len_nxt;
  always_comb begin
    len_nxt = word_valid_out ? len_r + 10'h001 : 10'h000;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      len_r <= 10'h000;
    end else begin
      len_r <= len_nxt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  mode_quiet_a:
    assert property (!serial_mode |-> serial_out_oe_n && !new_word_flag)
    else $error("output active before serial mode");
  sclk_follow_a:
    assert property ((serial_mode && conv_clk) [*4] |-> shift_clock_out)
    else $error("shift clock not following converter clock");
  oe_off_a:
    assert property (frame_enable_n [*4] |-> serial_out_oe_n)
    else $error("data driven while frame high");
  drive_frame_a:
    assert property ($fell(serial_out_oe_n) |-> !$past(frame_enable_n, 3))
    else $error("data driven before frame low");
  drive_word_a:
    assert property (!serial_out_oe_n |-> word_valid_out)
    else $error("data valid low while driving");
  bit_edge_a:
    assert property (!serial_out_oe_n && !$past(serial_out_oe_n) &&
      $changed(serial_out_line) |-> shift_clock_out)
    else $error("data changed off shift clock rise");
  word_len_a:
    assert property ($fell(word_valid_out) && !busy_out && !standby_out
      |-> len_r >= LEN_MIN && len_r <= LEN_MAX)
    else $error("word length wrong");
  flag_busy_a:
    assert property (busy_out |-> !new_word_flag)
    else $error("flag high during sync or calibration");
  sleep_enter_a:
    assert property ((serial_mode && sleep_select) [*5]
      |-> standby_out && !new_word_flag)
    else $error("standby not entered");
  realign_busy_a:
    assert property ($rose(realign_in) && serial_mode && !sleep_select
      |-> ##[1:6] busy_out)
    else $error("realign did not start sync");
  trim_busy_a:
    assert property ($rose(trim_request) && serial_mode && !sleep_select
      |-> ##[1:6] busy_out)
    else $error("trim did not start calibration");
endmodule : adc_serial_checker

bind adc_serial_port adc_serial_checker #(.WORD_W(WORD_W), .SETTLE(SETTLE))
  chk (.ref_clk, .rst_b, .conv_clk, .frame_enable_n, .realign_in,
  .trim_request, .sleep_select, .new_word_flag, .shift_clock_out,
  .serial_out_line, .serial_out_oe_n, .word_valid_out, .serial_mode,
  .standby_out, .busy_out);

// file: adc_serial_port_tb.sv
/*
  self-checking bench for the converter serial port with a host model.
  assumes design, host model and checker are compiled first.
*/
module adc_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, conv_clk, select_n, read_n, store_n;
  logic frame_enable_n, realign_in, range_polarity_select, trim_request;
  logic sleep_select, sample_valid, sample_ready, new_word_flag;
  logic shift_clock_out, serial_out_line, serial_out_oe_n, word_valid_out;
  logic serial_mode, standby_out, busy_out;
  logic [15:0] sample_data, rx_word;
  logic [15:0] got_q[$];
  int rx_count, waited;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  adc_serial_port #(.SETTLE(4)) dut (.ref_clk, .rst_b, .conv_clk,
    .select_n, .read_n, .store_n, .frame_enable_n, .realign_in,
    .range_polarity_select, .trim_request, .sleep_select, .sample_data,
    .sample_valid, .sample_ready, .new_word_flag, .shift_clock_out,
    .serial_out_line, .serial_out_oe_n, .word_valid_out, .serial_mode,
    .standby_out, .busy_out);
  host_rx_model host (.shift_clock_out, .serial_out_line, .serial_out_oe_n,
    .new_word_flag, .frame_enable_n, .select_n, .read_n, .store_n,
    .rx_word, .rx_count);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    conv_clk = 1'b0;
    #7;
    forever #24 conv_clk = ~conv_clk;
  end
  // short delay: word and count cross the ports in no fixed order
  always @(rx_count) #1 got_q.push_back(rx_word);
  // whole run needs about 1900 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check
  task automatic wait_lvl(ref logic s, input logic v, input int n);
    repeat (n) begin
      if (s === v) break;
      @(posedge ref_clk);
    end
  endtask : wait_lvl
  // idle cycle after each offer keeps valid from two writes in one step
  task automatic take_word();
    waited = 0;
    @(posedge ref_clk);
    while (sample_ready !== 1'b1 && waited < 3000) begin
      waited++;
      @(posedge ref_clk);
    end
    sample_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : take_word
  task automatic push(logic [15:0] w);
    sample_data <= w;
    sample_valid <= 1'b1;
    take_word();
  endtask : push
  task automatic expect_word(string name, logic [15:0] exp);
    logic [15:0] got;
    repeat (3000) begin
      if (got_q.size() != 0) break;
      @(posedge ref_clk);
    end
    got = got_q.size() != 0 ? got_q.pop_front() : 16'hXXXX;
    check(name, exp, got);
  endtask : expect_word
  task automatic t_mode();
    repeat (6) @(posedge ref_clk);
    check("mode early", 16'h0000, {15'h0000, serial_mode});
    wait_lvl(serial_mode, 1'b1, 14);
    check("mode late", 16'h0001, {15'h0000, serial_mode});
  endtask : t_mode
  task automatic t_burst();
    logic [15:0] w[4] = '{16'hA5C3, 16'h0001, 16'h8000, 16'hFFFE};
    foreach (w[i]) push(w[i]);
    check("full buffer stall", 16'h0001, {15'h0000, waited > 20});
    foreach (w[i]) expect_word("burst word", w[i]);
    repeat (20) @(posedge ref_clk);
    check("idle release", 16'h0001, {15'h0000, serial_out_oe_n});
  endtask : t_burst
  task automatic t_bipolar();
    range_polarity_select <= 1'b1;
    push(16'h1234);
    push(16'h8000);
    expect_word("bipolar word", 16'h9234);
    expect_word("bipolar mid", 16'h0000);
    range_polarity_select <= 1'b0;
  endtask : t_bipolar
  task automatic t_settle(logic trim);
    push(16'h3C3C);
    push(16'h4D4D);
    wait_lvl(word_valid_out, 1'b1, 400);
    if (trim) trim_request <= 1'b1;
    else realign_in <= 1'b1;
    // hold past one converter clock period so trim meets its minimum width
    repeat (12) @(posedge ref_clk);
    check("busy", 16'h0001, {15'h0000, busy_out});
    trim_request <= 1'b0;
    realign_in <= 1'b0;
    push(16'h5E5E);
    check("words dropped", 16'h0000, 16'(got_q.size()));
    expect_word("word after settle", 16'h5E5E);
  endtask : t_settle
  task automatic t_sleep();
    sleep_select <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check("standby", 16'h0001, {15'h0000, standby_out});
    // offer only once asleep, so no word is taken and then flushed
    sample_data <= 16'h6A6A;
    sample_valid <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("refused asleep", 16'h0000, {15'h0000, sample_ready});
    sleep_select <= 1'b0;
    take_word();
    expect_word("word after wake", 16'h6A6A);
  endtask : t_sleep
  initial begin
    rst_b = 1'b0;
    realign_in = 1'b0;
    trim_request = 1'b0;
    sleep_select = 1'b0;
    range_polarity_select = 1'b0;
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_mode();
    t_burst();
    t_bipolar();
    t_settle(1'b0);
    t_settle(1'b1);
    t_sleep();
    conclude();
  end
endmodule : adc_serial_port_tb
